// file: common/sdfc_pkg.sv
package sdfc_pkg;
  // ----------------------------------------
  // programming word layout
  // ----------------------------------------
  localparam int WORD_W = 24;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_AUX_N = 4'h3;
  localparam logic [3:0] CTRL_REF = 4'h5;
  localparam logic [3:0] CTRL_FL = 4'h7;
  localparam logic [3:0] CTRL_OPT = 4'hb;
  // auxiliary feedback word
  localparam int AUX_PD_BIT = 23;
  localparam int AUX_GAIN_BIT = 22;
  localparam int AUX_PRE_BIT = 21;
  localparam int AUX_N_LSB = 4;
  localparam int AUX_N_W = 17;
  localparam int AUX_N_UNUSED_BIT = 3;
  // reference divider word
  localparam int REF_DIV_LSB = 4;
  localparam int REF_DIV_W = 15;
  localparam int MAIN_GAIN_LSB = 19;
  localparam int CODE_W = 4;
  // fastlock word
  localparam int TOC_LSB = 4;
  localparam int TOC_W = 14;
  localparam int FL_CUR_LSB = 18;
  localparam int SLIP_LSB = 22;
  localparam int SLIP_W = 2;
  // option word
  localparam int AUX_PDMODE_BIT = 16;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic RST_AUX_PD = 1'b0;
  localparam logic RST_AUX_GAIN = 1'b0;
  localparam logic RST_AUX_PRE = 1'b0;
  localparam logic RST_AUX_PDMODE = 1'b0;
  localparam logic [16:0] RST_AUX_N = 17'h00000;
  localparam logic [14:0] RST_REF_DIV = 15'h0003;
  localparam logic [3:0] RST_CODE = 4'h0;
  localparam logic [13:0] RST_TOC = 14'h0000;
  localparam logic [1:0] RST_SLIP = 2'h0;
  // ----------------------------------------
  // values and timing
  // ----------------------------------------
  localparam logic [2:0] AUX_CP_LOW_MA = 3'h1;
  localparam logic [2:0] AUX_CP_HIGH_MA = 3'h4;
  localparam logic [4:0] PRE_SMALL = 5'h08;
  localparam logic [4:0] PRE_LARGE = 5'h10;
  localparam logic [10:0] CP_STEP_UA = 11'h064;
  localparam logic [13:0] TOC_HIZ = 14'h0000;
  localparam logic [13:0] TOC_MANUAL = 14'h0001;
  localparam logic [13:0] TOC_DRIVE_LO = 14'h0002;
  localparam logic [13:0] TOC_DRIVE_HI = 14'h0003;
  localparam logic [13:0] TOC_TIMED_MIN = 14'h0004;
  localparam int EVENTS_PER_TOC = 2;

  typedef enum {AUX_RUN, AUX_WAIT, AUX_DOWN} sdfc_aux_state_t;
  typedef enum {FL_IDLE, FL_TIMED} sdfc_fl_state_t;
endpackage

// file: common/sdfc_word_if.sv
`timescale 1ns/10ps
`default_nettype none
// carries one finished programming word from receiver to bank
interface sdfc_word_if;
  logic valid;
  logic [sdfc_pkg::WORD_W-1:0] word;
  modport rx (output valid, output word);
  modport bank (input valid, input word);
endinterface
`default_nettype wire

// file: rtl/sdfc_control.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// (R1) aux gain bit: 1 mA low, 4 mA high
// (R2) aux prescaler bit: 8/9 or 16/17
// (R3) aux power-down stops loop, pump high-Z
// (R4) mode 0: power-down waits for idle pump
// (R5) mode 1: power-down takes effect at once
// (R6) aux reference divides by plain 15-bit value
// (R7) host keeps reference divide at least 3
// (R8) main gain code gives (code+1)*100 uA
// (R9) timeout 0, 2, 3: no fastlock, pin general-purpose
// (R10) timeout 0 hi-Z, 2 low, 3 high
// (R11) timeout 1: pin low, fastlock held continuously
// (R12) timeout 4..16383: timed fastlock drives pin
// (R13) fastlock lasts timeout*2 pump events
// (R14) fastlock current code gives (code+1)*100 uA
// (R15) aux N binary, bit 3 unused with 8/9
// (R16) 24-bit words, low nibble selects register
// (R17) host keeps swallow count legal for 16/17
module sdfc_control #(
  parameter int TIMER_W = 15
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // three-wire programming port
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  // loop status
  input wire logic aux_pump_active,
  input wire logic aux_ref_in,
  input wire logic main_cmp_event,
  input wire logic main_tune_start,
  // auxiliary loop controls
  output logic [2:0] aux_pump_ma,
  output logic [4:0] aux_prescaler_mod,
  output logic [3:0] aux_swallow,
  output logic [12:0] aux_main_count,
  output logic aux_powered,
  output logic aux_pump_hiz,
  output logic aux_ref_tick,
  // main loop controls
  output logic [10:0] main_pump_ua,
  output logic main_fastlock_active,
  output logic [1:0] slip_reduction_select,
  // fastlock pin
  output logic main_fastlock_pin_out,
  output logic main_fastlock_pin_oe
);
  sdfc_word_if wif ();
  // ------------------------------------
  // serial word receiver
  // ------------------------------------
  sdfc_serial_rx u_rx (
    .core_clk(core_clk),
    .srst(srst),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .ser_le(ser_le),
    .out(wif.rx)
  );

  // ------------------------------------
  // programmed fields
  // ------------------------------------
  logic aux_pd;
  logic aux_gain;
  logic aux_pre;
  logic aux_pdmode;
  logic [16:0] aux_n;
  logic [14:0] ref_div;
  logic [3:0] main_gain;
  logic [3:0] fl_cur;
  logic [13:0] toc;
  logic [1:0] slip;
  logic next_aux_pd;
  logic next_aux_gain;
  logic next_aux_pre;
  logic next_aux_pdmode;
  logic [16:0] next_aux_n;
  logic [14:0] next_ref_div;
  logic [3:0] next_main_gain;
  logic [3:0] next_fl_cur;
  logic [13:0] next_toc;
  logic [1:0] next_slip;
  // word decode by control nibble
  always_comb begin
    next_aux_pd = aux_pd;
    next_aux_gain = aux_gain;
    next_aux_pre = aux_pre;
    next_aux_pdmode = aux_pdmode;
    next_aux_n = aux_n;
    next_ref_div = ref_div;
    next_main_gain = main_gain;
    next_fl_cur = fl_cur;
    next_toc = toc;
    next_slip = slip;
    if (wif.valid) begin
      case (wif.word[sdfc_pkg::CTRL_W-1:0]) // (R16)
        sdfc_pkg::CTRL_AUX_N: begin
          next_aux_pd = wif.word[sdfc_pkg::AUX_PD_BIT];
          next_aux_gain = wif.word[sdfc_pkg::AUX_GAIN_BIT];
          next_aux_pre = wif.word[sdfc_pkg::AUX_PRE_BIT];
          next_aux_n = wif.word[sdfc_pkg::AUX_N_LSB +: sdfc_pkg::AUX_N_W];
        end
        sdfc_pkg::CTRL_REF: begin
          next_ref_div = wif.word[sdfc_pkg::REF_DIV_LSB +: sdfc_pkg::REF_DIV_W];
          next_main_gain = wif.word[sdfc_pkg::MAIN_GAIN_LSB +: sdfc_pkg::CODE_W];
        end
        sdfc_pkg::CTRL_FL: begin
          next_toc = wif.word[sdfc_pkg::TOC_LSB +: sdfc_pkg::TOC_W];
          next_fl_cur = wif.word[sdfc_pkg::FL_CUR_LSB +: sdfc_pkg::CODE_W];
          next_slip = wif.word[sdfc_pkg::SLIP_LSB +: sdfc_pkg::SLIP_W];
        end
        sdfc_pkg::CTRL_OPT: next_aux_pdmode = wif.word[sdfc_pkg::AUX_PDMODE_BIT];
        default: next_aux_pd = aux_pd; // other words belong elsewhere
      endcase
    end
  end

  // field registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      aux_pd <= sdfc_pkg::RST_AUX_PD;
      aux_gain <= sdfc_pkg::RST_AUX_GAIN;
      aux_pre <= sdfc_pkg::RST_AUX_PRE;
      aux_pdmode <= sdfc_pkg::RST_AUX_PDMODE;
      aux_n <= sdfc_pkg::RST_AUX_N;
      ref_div <= sdfc_pkg::RST_REF_DIV;
      main_gain <= sdfc_pkg::RST_CODE;
      fl_cur <= sdfc_pkg::RST_CODE;
      toc <= sdfc_pkg::RST_TOC;
      slip <= sdfc_pkg::RST_SLIP;
    end else begin
      aux_pd <= next_aux_pd;
      aux_gain <= next_aux_gain;
      aux_pre <= next_aux_pre;
      aux_pdmode <= next_aux_pdmode;
      aux_n <= next_aux_n;
      ref_div <= next_ref_div;
      main_gain <= next_main_gain;
      fl_cur <= next_fl_cur;
      toc <= next_toc;
      slip <= next_slip;
    end
  end

  // ------------------------------------
  // auxiliary power-down sequencing
  // ------------------------------------
  sdfc_pkg::sdfc_aux_state_t aux_st;
  sdfc_pkg::sdfc_aux_state_t next_aux_st;
  always_comb begin
    next_aux_st = aux_st;
    case (aux_st)
      sdfc_pkg::AUX_RUN: begin
        if (aux_pd && (aux_pdmode || !aux_pump_active)) begin
          next_aux_st = sdfc_pkg::AUX_DOWN; // (R4) (R5)
        end else if (aux_pd) begin
          next_aux_st = sdfc_pkg::AUX_WAIT; // (R4)
        end
      end
      sdfc_pkg::AUX_WAIT: begin
        if (!aux_pd) begin
          next_aux_st = sdfc_pkg::AUX_RUN;
        end else if (aux_pdmode || !aux_pump_active) begin
          next_aux_st = sdfc_pkg::AUX_DOWN; // (R4)
        end
      end
      sdfc_pkg::AUX_DOWN: begin
        if (!aux_pd) begin
          next_aux_st = sdfc_pkg::AUX_RUN; // (R3)
        end
      end
      default: begin
        next_aux_st = sdfc_pkg::AUX_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      aux_st <= sdfc_pkg::AUX_RUN;
    end else begin
      aux_st <= next_aux_st;
    end
  end

  // ------------------------------------
  // auxiliary reference divider
  // ------------------------------------
  logic [14:0] ref_cnt;
  logic [14:0] next_ref_cnt;
  logic next_ref_tick;
  // counts cycles with aux_ref_in high, divider must stay at 3 or more
  always_comb begin
    next_ref_cnt = ref_cnt;
    next_ref_tick = 1'b0;
    if (next_aux_st == sdfc_pkg::AUX_DOWN) begin
      next_ref_cnt = '0;
    end else if (aux_ref_in) begin
      if (ref_cnt >= ref_div - 15'h0001) begin // (R6) (R7)
        next_ref_cnt = '0;
        next_ref_tick = 1'b1;
      end else begin
        next_ref_cnt = ref_cnt + 15'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ref_cnt <= '0;
    end else begin
      ref_cnt <= next_ref_cnt;
    end
  end

  // ------------------------------------
  // main fastlock timer
  // ------------------------------------
  sdfc_pkg::sdfc_fl_state_t fl_st;
  sdfc_pkg::sdfc_fl_state_t next_fl_st;
  logic [TIMER_W-1:0] fl_cnt;
  logic [TIMER_W-1:0] next_fl_cnt;
  logic timed_mode;
  logic manual_mode;
  logic [TIMER_W-1:0] fl_len;
  assign timed_mode = (toc >= sdfc_pkg::TOC_TIMED_MIN); // (R12)
  assign manual_mode = (toc == sdfc_pkg::TOC_MANUAL); // (R11)
  assign fl_len = TIMER_W'(toc) * TIMER_W'(sdfc_pkg::EVENTS_PER_TOC); // (R13)
  always_comb begin
    next_fl_st = fl_st;
    next_fl_cnt = fl_cnt;
    case (fl_st)
      sdfc_pkg::FL_IDLE: begin
        if (main_tune_start && timed_mode) begin
          next_fl_st = sdfc_pkg::FL_TIMED; // (R12)
          next_fl_cnt = fl_len;
        end
      end
      sdfc_pkg::FL_TIMED: begin
        if (!timed_mode) begin
          next_fl_st = sdfc_pkg::FL_IDLE; // (R9)
          next_fl_cnt = '0;
        end else if (main_tune_start) begin
          next_fl_cnt = fl_len;
        end else if (main_cmp_event) begin
          next_fl_cnt = fl_cnt - TIMER_W'(1); // (R13)
          if (fl_cnt == TIMER_W'(1)) begin
            next_fl_st = sdfc_pkg::FL_IDLE;
          end
        end
      end
      default: begin
        next_fl_st = sdfc_pkg::FL_IDLE;
        next_fl_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fl_st <= sdfc_pkg::FL_IDLE;
      fl_cnt <= '0;
    end else begin
      fl_st <= next_fl_st;
      fl_cnt <= next_fl_cnt;
    end
  end

  // ------------------------------------
  // registered outputs
  // ------------------------------------
  logic fl_on;
  logic [2:0] next_aux_pump_ma;
  logic [4:0] next_prescaler_mod;
  logic [3:0] next_swallow;
  logic [10:0] next_main_pump_ua;
  logic next_pin_out;
  logic next_pin_oe;
  assign fl_on = manual_mode || (next_fl_st == sdfc_pkg::FL_TIMED);
  always_comb begin
    next_aux_pump_ma = aux_gain ? sdfc_pkg::AUX_CP_HIGH_MA : sdfc_pkg::AUX_CP_LOW_MA; // (R1)
    next_prescaler_mod = aux_pre ? sdfc_pkg::PRE_LARGE : sdfc_pkg::PRE_SMALL; // (R2)
    // swallow count; bit 3 ignored for 8/9 (R15)
    next_swallow = aux_pre ? aux_n[3:0] : {1'b0, aux_n[2:0]};
    if (fl_on) begin
      next_main_pump_ua = 11'(({7'h00, fl_cur} + 11'h001) * sdfc_pkg::CP_STEP_UA); // (R14)
    end else begin
      next_main_pump_ua = 11'(({7'h00, main_gain} + 11'h001) * sdfc_pkg::CP_STEP_UA); // (R8)
    end
    next_pin_out = 1'b0;
    next_pin_oe = 1'b1;
    case (toc)
      sdfc_pkg::TOC_HIZ: next_pin_oe = 1'b0; // (R10)
      sdfc_pkg::TOC_MANUAL: next_pin_out = 1'b0; // (R11)
      sdfc_pkg::TOC_DRIVE_LO: next_pin_out = 1'b0; // (R10)
      sdfc_pkg::TOC_DRIVE_HI: next_pin_out = 1'b1; // (R10)
      default: next_pin_oe = fl_on; // (R12) pulls low in fastlock
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      aux_pump_ma <= sdfc_pkg::AUX_CP_LOW_MA;
      aux_prescaler_mod <= sdfc_pkg::PRE_SMALL;
      aux_swallow <= '0;
      aux_main_count <= '0;
      aux_powered <= 1'b1;
      aux_pump_hiz <= 1'b0;
      aux_ref_tick <= 1'b0;
      main_pump_ua <= sdfc_pkg::CP_STEP_UA;
      main_fastlock_active <= 1'b0;
      slip_reduction_select <= sdfc_pkg::RST_SLIP;
      main_fastlock_pin_out <= 1'b0;
      main_fastlock_pin_oe <= 1'b0;
    end else begin
      aux_pump_ma <= next_aux_pump_ma;
      aux_prescaler_mod <= next_prescaler_mod;
      aux_swallow <= next_swallow;
      aux_main_count <= aux_n[16:4]; // (R15)
      aux_powered <= (next_aux_st != sdfc_pkg::AUX_DOWN); // (R3)
      aux_pump_hiz <= (next_aux_st == sdfc_pkg::AUX_DOWN); // (R3)
      aux_ref_tick <= next_ref_tick;
      main_pump_ua <= next_main_pump_ua;
      main_fastlock_active <= fl_on; // (R9)
      slip_reduction_select <= slip;
      main_fastlock_pin_out <= next_pin_out;
      main_fastlock_pin_oe <= next_pin_oe;
    end
  end
endmodule
`default_nettype wire

// file: rtl/sdfc_serial_rx.sv
`timescale 1ns/10ps
`default_nettype none
module sdfc_serial_rx (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // three-wire port
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  // finished word
  sdfc_word_if.rx out
);
  logic ser_clk_d;
  logic ser_le_d;
  logic [sdfc_pkg::WORD_W-1:0] shift;
  logic valid;
  logic [sdfc_pkg::WORD_W-1:0] word;
  logic next_ser_clk_d;
  logic next_ser_le_d;
  logic [sdfc_pkg::WORD_W-1:0] next_shift;
  logic next_valid;
  logic [sdfc_pkg::WORD_W-1:0] next_word;

  // ------------------------------------
  // shift on clock rise, latch on load rise
  // ------------------------------------
  always_comb begin
    next_ser_clk_d = ser_clk;
    next_ser_le_d = ser_le;
    next_shift = shift;
    next_valid = 1'b0;
    next_word = word;
    if (ser_clk && !ser_clk_d && !ser_le) begin
      next_shift = {shift[sdfc_pkg::WORD_W-2:0], ser_data}; // msb first
    end
    if (ser_le && !ser_le_d) begin
      next_valid = 1'b1; // (R16)
      next_word = shift;
    end
  end

  // state registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ser_clk_d <= 1'b0;
      ser_le_d <= 1'b0;
      shift <= '0;
      valid <= 1'b0;
      word <= '0;
    end else begin
      ser_clk_d <= next_ser_clk_d;
      ser_le_d <= next_ser_le_d;
      shift <= next_shift;
      valid <= next_valid;
      word <= next_word;
    end
  end

  assign out.valid = valid;
  assign out.word = word;
endmodule
`default_nettype wire

// file: verif/sdfc_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sdfc_control_bench;
  logic core_clk, srst, ser_clk, ser_data, ser_le, aux_pump_active, aux_ref_in, main_cmp_event;
  logic main_tune_start, aux_powered, aux_pump_hiz, aux_ref_tick, main_fastlock_active, pin_out, pin_oe;
  logic [2:0] aux_pump_ma;
  logic [4:0] aux_prescaler_mod;
  logic [3:0] aux_swallow;
  logic [12:0] aux_main_count;
  logic [10:0] main_pump_ua;
  logic [1:0] slip;
  int n_fail = 0;
  int check_count = 0;
  // clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  sdfc_host_model host_u (.core_clk(core_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le));
  sdfc_control dut_u (
    .core_clk(core_clk), .srst(srst), .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le),
    .aux_pump_active(aux_pump_active), .aux_ref_in(aux_ref_in), .main_cmp_event(main_cmp_event),
    .main_tune_start(main_tune_start), .aux_pump_ma(aux_pump_ma), .aux_prescaler_mod(aux_prescaler_mod),
    .aux_swallow(aux_swallow), .aux_main_count(aux_main_count), .aux_powered(aux_powered),
    .aux_pump_hiz(aux_pump_hiz), .aux_ref_tick(aux_ref_tick), .main_pump_ua(main_pump_ua),
    .main_fastlock_active(main_fastlock_active), .slip_reduction_select(slip),
    .main_fastlock_pin_out(pin_out), .main_fastlock_pin_oe(pin_oe)
  );
  // -----------------------------
  // checking and closing
  // -----------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for pump hiz
  task automatic wait_hiz();
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk);
      if (aux_pump_hiz === 1'b1) return;
    end
    n_fail++;
    tally_and_finish();
  endtask
  // -----------------------------
  // scenarios
  // -----------------------------
  task automatic t_aux();
    host_u.send_word({1'b0, 1'b1, 1'b1, 17'h000f3, 4'h3});
    chk_val(16'(aux_pump_ma), 16'h0004);
    chk_val(16'(aux_prescaler_mod), 16'h0010);
    chk_val({aux_swallow, 12'(aux_main_count)}, 16'h300f);
    host_u.send_word({1'b0, 1'b0, 1'b0, 17'h000f5, 4'h3});
    chk_val(16'(aux_pump_ma), 16'h0001);
    chk_val(16'(aux_prescaler_mod), 16'h0008);
    chk_val({aux_swallow, 12'(aux_main_count)}, 16'h500f);
  endtask
  task automatic t_power();
    aux_pump_active = 1'b1;
    host_u.send_word({7'h00, 1'b0, 12'h000, 4'hb});
    host_u.send_word({1'b1, 2'h0, 17'h000f5, 4'h3});
    chk_val(16'(aux_powered), 16'h0001);
    aux_pump_active = 1'b0;
    wait_hiz();
    chk_val(16'(aux_powered), 16'h0000);
    aux_pump_active = 1'b1;
    host_u.send_word({1'b0, 2'h0, 17'h000f5, 4'h3});
    chk_val(16'(aux_powered), 16'h0001);
    host_u.send_word({7'h00, 1'b1, 12'h000, 4'hb});
    host_u.send_word({1'b1, 2'h0, 17'h000f5, 4'h3});
    chk_val(16'(aux_pump_hiz), 16'h0001);
    host_u.send_word({1'b0, 2'h0, 17'h000f5, 4'h3});
  endtask
  task automatic t_ref();
    int ticks;
    ticks = 0;
    host_u.send_word({1'b0, 4'hf, 15'h0005, 4'h5});
    chk_val(16'(main_pump_ua), 16'h0640);
    host_u.send_word({1'b0, 4'h0, 15'h0003, 4'h1});
    chk_val(16'(main_pump_ua), 16'h0640);
    for (int i = 0; i < 10; i++) begin
      aux_ref_in = 1'b1;
      @(negedge core_clk);
      aux_ref_in = 1'b0;
      if (aux_ref_tick === 1'b1) ticks++;
      @(negedge core_clk);
      if (aux_ref_tick === 1'b1) ticks++;
    end
    chk_val(16'(ticks), 16'h0002);
  endtask
  task automatic t_pin();
    logic [13:0] toc [3] = '{14'h0000, 14'h0002, 14'h0003};
    logic [1:0] exp [3] = '{2'h0, 2'h2, 2'h3};
    for (int i = 0; i < 3; i++) begin
      host_u.send_word({2'h0, 4'h0, toc[i], 4'h7});
      chk_val(16'({pin_oe, pin_out & pin_oe}), 16'(exp[i]));
      chk_val(16'(main_fastlock_active), 16'h0000);
    end
  endtask
  task automatic t_timed();
    host_u.send_word({2'h1, 4'h9, 14'h0004, 4'h7});
    chk_val(16'(pin_oe), 16'h0000);
    chk_val(16'(slip), 16'h0001);
    main_tune_start = 1'b1;
    @(negedge core_clk);
    main_tune_start = 1'b0;
    @(negedge core_clk);
    chk_val({pin_oe, pin_out, 14'(main_pump_ua)}, 16'h83e8);
    for (int i = 0; i < 8; i++) begin
      main_cmp_event = 1'b1;
      @(negedge core_clk);
      main_cmp_event = 1'b0;
      @(negedge core_clk);
      if (i == 6) chk_val(16'(main_fastlock_active), 16'h0001);
    end
    @(negedge core_clk);
    chk_val(16'(main_fastlock_active), 16'h0000);
    chk_val(16'(main_pump_ua), 16'h0640);
  endtask
  task automatic t_manual();
    host_u.send_word({2'h0, 4'h2, 14'h0001, 4'h7});
    chk_val({pin_oe, pin_out, 14'(main_pump_ua)}, 16'h812c);
  endtask
  // -----------------------------
  // main sequence
  // -----------------------------
  initial begin
    srst = 1'b1;
    aux_pump_active = 1'b0;
    aux_ref_in = 1'b0;
    main_cmp_event = 1'b0;
    main_tune_start = 1'b0;
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    chk_val({aux_powered, pin_oe, 3'h0, main_pump_ua}, 16'h8064);
    t_aux();
    t_power();
    t_ref();
    t_pin();
    t_timed();
    t_manual();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: verif/sdfc_control_properties.sv
`timescale 1ns/10ps
`default_nettype none
module sdfc_control_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // watched ports
  input wire logic aux_ref_in,
  input wire logic main_cmp_event,
  input wire logic [2:0] aux_pump_ma,
  input wire logic [4:0] aux_prescaler_mod,
  input wire logic aux_powered,
  input wire logic aux_pump_hiz,
  input wire logic aux_ref_tick,
  input wire logic [10:0] main_pump_ua,
  input wire logic main_fastlock_active,
  input wire logic main_fastlock_pin_out,
  input wire logic main_fastlock_pin_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // -----------------------------
  // sequences
  // -----------------------------
  sequence s_fl_end;
    $fell(main_fastlock_active);
  endsequence
  sequence s_tick;
    aux_ref_tick;
  endsequence
  // -----------------------------
  // properties
  // -----------------------------
  property p_aux_ma;
    aux_pump_ma == 3'h1 || aux_pump_ma == 3'h4;
  endproperty
  property p_pre;
    aux_prescaler_mod == 5'h08 || aux_prescaler_mod == 5'h10;
  endproperty
  property p_hiz;
    aux_pump_hiz == !aux_powered ##1 aux_pump_hiz == !aux_powered;
  endproperty
  property p_tick_pulse;
    s_tick |=> !aux_ref_tick [*2];
  endproperty
  property p_tick_cause;
    s_tick |-> $past(aux_ref_in) && aux_powered;
  endproperty
  property p_main_ua;
    main_pump_ua >= 11'h064 && main_pump_ua <= 11'h640 && main_pump_ua % 11'h064 == 11'h000;
  endproperty
  property p_fl_pin;
    main_fastlock_active && main_fastlock_pin_oe |-> !main_fastlock_pin_out;
  endproperty
  property p_fl_end;
    s_fl_end |-> $past(main_cmp_event);
  endproperty
  a_aux_ma: assert property (p_aux_ma) else $error("aux pump current not 1 or 4");
  a_pre: assert property (p_pre) else $error("aux prescaler not 8 or 16");
  a_hiz: assert property (p_hiz) else $error("aux hiz not inverse of powered");
  a_tick_pulse: assert property (p_tick_pulse) else $error("ref tick too long");
  a_tick_cause: assert property (p_tick_cause) else $error("ref tick without input");
  a_main_ua: assert property (p_main_ua) else $error("main pump current off grid");
  a_fl_pin: assert property (p_fl_pin) else $error("fastlock pin not low");
  a_fl_end: assert property (p_fl_end) else $error("fastlock ended off event");
endmodule
bind sdfc_control sdfc_control_properties chk_u (
  .core_clk(core_clk), .srst(srst), .aux_ref_in(aux_ref_in), .main_cmp_event(main_cmp_event),
  .aux_pump_ma(aux_pump_ma), .aux_prescaler_mod(aux_prescaler_mod), .aux_powered(aux_powered),
  .aux_pump_hiz(aux_pump_hiz), .aux_ref_tick(aux_ref_tick), .main_pump_ua(main_pump_ua),
  .main_fastlock_active(main_fastlock_active), .main_fastlock_pin_out(main_fastlock_pin_out),
  .main_fastlock_pin_oe(main_fastlock_pin_oe)
);
`default_nettype wire

// file: verif/sdfc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host side of the three-wire programming port
module sdfc_host_model (
  // clock
  input wire logic core_clk,
  // three-wire port
  output logic ser_clk,
  output logic ser_data,
  output logic ser_le
);
  // port idles with clock low and load enable low
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_le = 1'b0;
  end
  // shift 24 bits msb first, then pulse load enable
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      @(negedge core_clk);
      ser_clk = 1'b0;
      ser_data = w[i];
      @(negedge core_clk);
      ser_clk = 1'b1;
    end
    @(negedge core_clk);
    ser_clk = 1'b0;
    ser_data = ~w[0]; // data line no longer valid after the frame
    ser_le = 1'b1;
    repeat (2) @(negedge core_clk);
    ser_le = 1'b0;
    repeat (5) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire
